// [rx_dma_ctrl_pkg.sv]
// Shared constants for the receive DMA control block
package rx_dma_ctrl_pkg;
    localparam logic [11:0] RX_DMA_CTRL_OFFSET = 12'h0D0;
    localparam logic [11:0] RX_DMA_STATUS_OFFSET = 12'h100;
    localparam logic [31:0] RX_DMA_CTRL_RESET = 32'h0000_0000;
    localparam int REPORT_REJECTED_STATUS_BIT = 31;
    localparam int ACCEPT_RUNT_FRAMES_BIT = 30;
    localparam int ACCEPT_DAMAGED_FRAMES_BIT = 29;
    localparam int ACCEPT_CHECKSUM_FAIL_FRAMES_BIT = 28;
    localparam int PASS_MAC_CONTROL_FRAMES_BIT = 27;
    localparam int PASS_FLOW_PAUSE_FRAMES_BIT = 26;
    localparam int L4_CHECKSUM_FILTER_SELECT_LSB = 24;
    localparam int SECOND_COMPLETION_QUEUE_ON_BIT = 23;
    localparam int BUFFER_QUEUE_SELECT_MODE_LSB = 20;
    localparam int FALLBACK_QUEUE_ON_BIT = 19;
    localparam int KEEP_FRAME_FCS_BIT = 18;
    localparam int EARLY_NOTIFY_BYTE_THRESHOLD_LSB = 12;
    localparam logic [31:0] RX_DMA_CTRL_WR_MASK = 32'hFFFD_F000;
    localparam int MIN_FRAME_BYTES = 64;
    localparam int FCS_BYTES = 4;
    localparam int EARLY_THRESHOLD_UNIT_BYTES = 64;
    typedef enum logic [1:0] {
        CSUM_IGNORE,
        CSUM_REJECT_TCP,
        CSUM_REJECT_TCP_UDP,
        CSUM_RESERVED
    } l4_checksum_filter_e;
    typedef enum logic [2:0] {
        QMODE_Q1_ONLY,
        QMODE_Q1_FP_Q2,
        QMODE_BY_SIZE,
        QMODE_BY_PRIORITY,
        QMODE_HEADER_SPLIT,
        QMODE_RSVD5,
        QMODE_RSVD6,
        QMODE_RSVD7
    } buffer_queue_select_mode_e;
endpackage : rx_dma_ctrl_pkg

// [rx_queue_select.sv]
// Buffer and completion queue choice for one received frame
module rx_queue_select #(
    parameter int LEN_W = 16
) (
    input wire logic [2:0] i_mode,
    input wire logic i_fallback_queue_on,
    input wire logic i_second_completion_queue_on,
    input wire logic i_frm_hi_prio,
    input wire logic i_frm_is_ip,
    input wire logic i_frm_complete,
    input wire logic [LEN_W-1:0] i_frm_bytes_rcvd,
    input wire logic [LEN_W-1:0] i_second_queue_buffer_bytes,
    input wire logic i_fp_len_valid,
    input wire logic [LEN_W-1:0] i_fp_len,
    input wire logic i_fp_queue_override,
    input wire logic i_fp_queue_sel,
    input wire logic i_fp_cmpl_override,
    input wire logic i_fp_cmpl_sel,
    input wire logic i_q1_empty,
    input wire logic i_q2_empty,
    output logic o_buf_queue,
    output logic o_header_split,
    output logic o_xfer_start_ok,
    output logic o_cmpl_queue
);
    logic [LEN_W-1:0] known_len;
    logic len_known;
    logic mode_q;
    logic ovr_q;

    always_comb begin
        known_len = i_fp_len_valid ? i_fp_len : i_frm_bytes_rcvd;
        len_known = i_fp_len_valid | i_frm_complete;
        mode_q = 1'b0;
        o_header_split = 1'b0;
        o_xfer_start_ok = 1'b1;
        case (rx_dma_ctrl_pkg::buffer_queue_select_mode_e'(i_mode))
            rx_dma_ctrl_pkg::QMODE_Q1_ONLY: begin
                mode_q = 1'b0;
            end
            rx_dma_ctrl_pkg::QMODE_Q1_FP_Q2: begin
                mode_q = 1'b0;
            end
            rx_dma_ctrl_pkg::QMODE_BY_SIZE: begin
                // Wait for the q2 buffer length, the whole frame or a length from the frame processor
                o_xfer_start_ok = len_known || (i_frm_bytes_rcvd >= i_second_queue_buffer_bytes);
                mode_q = len_known && (known_len <= i_second_queue_buffer_bytes);
            end
            rx_dma_ctrl_pkg::QMODE_BY_PRIORITY: begin
                mode_q = i_frm_hi_prio;
            end
            rx_dma_ctrl_pkg::QMODE_HEADER_SPLIT: begin
                o_header_split = i_frm_is_ip;
                mode_q = !i_frm_is_ip;
            end
            default: begin
                mode_q = 1'b0;
            end
        endcase
        ovr_q = (i_mode != 3'h0 && i_fp_queue_override) ? i_fp_queue_sel : mode_q;
        o_buf_queue = ovr_q;
        // Fallback only for a single-queue choice
        if (i_mode != 3'h0 && i_fallback_queue_on && !o_header_split) begin
            if (ovr_q ? i_q2_empty : i_q1_empty) begin
                o_buf_queue = !ovr_q;
            end
        end
        o_cmpl_queue = 1'b0;
        if (i_second_completion_queue_on) begin
            o_cmpl_queue = i_fp_cmpl_override ? i_fp_cmpl_sel : i_frm_hi_prio;
        end
    end
endmodule : rx_queue_select

// [rx_dma_ctrl.sv]
// Receive DMA control register, frame filter, queue choice, FCS strip and early notify
module rx_dma_ctrl #(
    parameter int LEN_W = 16
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic i_long_completion_mode,
    input wire logic i_frm_end,
    input wire logic [LEN_W-1:0] i_frm_len,
    input wire logic i_frm_dribble,
    input wire logic i_frm_code_violation,
    input wire logic i_frm_fifo_overflow,
    input wire logic i_frm_crc_error,
    input wire logic i_frm_is_mac_control,
    input wire logic i_frm_is_pause,
    input wire logic i_frm_is_tcp,
    input wire logic i_frm_is_udp,
    input wire logic i_frm_l4_checksum_bad,
    input wire logic i_frm_hi_prio,
    input wire logic i_frm_is_ip,
    input wire logic i_frm_start,
    input wire logic i_frm_complete,
    input wire logic [LEN_W-1:0] i_frm_bytes_rcvd,
    input wire logic [LEN_W-1:0] i_second_queue_buffer_bytes,
    input wire logic i_fp_len_valid,
    input wire logic [LEN_W-1:0] i_fp_len,
    input wire logic i_fp_queue_override,
    input wire logic i_fp_queue_sel,
    input wire logic i_fp_cmpl_override,
    input wire logic i_fp_cmpl_sel,
    input wire logic i_q1_empty,
    input wire logic i_q2_empty,
    input wire logic [LEN_W-1:0] i_dma_bytes_done,
    output logic o_decision_valid,
    output logic o_frm_accept,
    output logic o_frm_post_status,
    output logic o_frm_stats_only,
    output logic [LEN_W-1:0] o_xfer_len,
    output logic o_buf_queue,
    output logic o_header_split,
    output logic o_xfer_start_ok,
    output logic o_cmpl_queue,
    output logic o_early_arrival_interrupt
);
    if (LEN_W < 12 || LEN_W > 24) begin : g_len_check
        $error("rx_dma_ctrl: LEN_W out of range");
    end

    localparam logic [LEN_W-1:0] MIN_LEN = LEN_W'(rx_dma_ctrl_pkg::MIN_FRAME_BYTES);
    localparam logic [LEN_W-1:0] FCS_LEN = LEN_W'(rx_dma_ctrl_pkg::FCS_BYTES);
    localparam int THR_SHIFT = $clog2(rx_dma_ctrl_pkg::EARLY_THRESHOLD_UNIT_BYTES);

    // Register bus state
    logic [31:0] ctrl_ff;
    logic [31:0] nxt_ctrl;
    logic pready_ff;
    logic nxt_pready;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic pslverr_ff;
    logic nxt_pslverr;

    // Frame and queue state
    logic decision_valid_ff;
    logic nxt_decision_valid;
    logic accept_ff;
    logic nxt_accept;
    logic post_status_ff;
    logic nxt_post_status;
    logic stats_only_ff;
    logic nxt_stats_only;
    logic [LEN_W-1:0] xfer_len_ff;
    logic [LEN_W-1:0] nxt_xfer_len;
    logic buf_queue_ff;
    logic nxt_buf_queue;
    logic header_split_ff;
    logic nxt_header_split;
    logic start_ok_ff;
    logic nxt_start_ok;
    logic cmpl_queue_ff;
    logic nxt_cmpl_queue;
    logic early_fired_ff;
    logic nxt_early_fired;
    logic early_pulse_ff;
    logic nxt_early_pulse;
    logic [7:0] reject_count_ff;
    logic [7:0] nxt_reject_count;

    logic [1:0] csum_sel;
    logic [2:0] queue_mode;
    logic [4:0] early_thr;
    logic [LEN_W-1:0] early_bytes;
    logic q_sel;
    logic q_split;
    logic q_start_ok;
    logic q_cmpl;
    logic rej_any;
    logic [31:0] status_word;

    assign csum_sel = ctrl_ff[rx_dma_ctrl_pkg::L4_CHECKSUM_FILTER_SELECT_LSB +: 2];
    assign queue_mode = ctrl_ff[rx_dma_ctrl_pkg::BUFFER_QUEUE_SELECT_MODE_LSB +: 3];
    assign early_thr = ctrl_ff[rx_dma_ctrl_pkg::EARLY_NOTIFY_BYTE_THRESHOLD_LSB +: 5];
    assign early_bytes = LEN_W'({early_thr, {THR_SHIFT{1'b0}}});

    rx_queue_select #(
        .LEN_W(LEN_W)
    ) u_queue_select (
        .i_mode(queue_mode),
        .i_fallback_queue_on(ctrl_ff[rx_dma_ctrl_pkg::FALLBACK_QUEUE_ON_BIT]),
        .i_second_completion_queue_on(ctrl_ff[rx_dma_ctrl_pkg::SECOND_COMPLETION_QUEUE_ON_BIT]),
        .i_frm_hi_prio(i_frm_hi_prio),
        .i_frm_is_ip(i_frm_is_ip),
        .i_frm_complete(i_frm_complete),
        .i_frm_bytes_rcvd(i_frm_bytes_rcvd),
        .i_second_queue_buffer_bytes(i_second_queue_buffer_bytes),
        .i_fp_len_valid(i_fp_len_valid),
        .i_fp_len(i_fp_len),
        .i_fp_queue_override(i_fp_queue_override),
        .i_fp_queue_sel(i_fp_queue_sel),
        .i_fp_cmpl_override(i_fp_cmpl_override),
        .i_fp_cmpl_sel(i_fp_cmpl_sel),
        .i_q1_empty(i_q1_empty),
        .i_q2_empty(i_q2_empty),
        .o_buf_queue(q_sel),
        .o_header_split(q_split),
        .o_xfer_start_ok(q_start_ok),
        .o_cmpl_queue(q_cmpl)
    );

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[0] = accept_ff;
        status_word[1] = post_status_ff;
        status_word[2] = buf_queue_ff;
        status_word[3] = header_split_ff;
        status_word[4] = cmpl_queue_ff;
        status_word[5] = early_fired_ff;
        status_word[15:8] = reject_count_ff;
    end

    // Zero-wait APB slave: answer prepared in setup, pready high through access
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_pready = 1'b0;
        nxt_prdata = prdata_ff;
        nxt_pslverr = 1'b0;
        if (i_psel && !i_penable) begin
            nxt_pready = 1'b1;
            nxt_prdata = 32'h0000_0000;
            if (i_paddr == rx_dma_ctrl_pkg::RX_DMA_CTRL_OFFSET) begin
                nxt_prdata = ctrl_ff;
            end else if (i_paddr == rx_dma_ctrl_pkg::RX_DMA_STATUS_OFFSET && !i_pwrite) begin
                nxt_prdata = status_word;
            end else begin
                nxt_pslverr = 1'b1;
            end
        end else if (i_psel && i_penable && !pready_ff) begin
            nxt_pready = 1'b1;
            nxt_pslverr = pslverr_ff;
        end
        if (i_psel && i_penable && pready_ff && i_pwrite && i_paddr == rx_dma_ctrl_pkg::RX_DMA_CTRL_OFFSET) begin
            // Bit 17 and the unimplemented low fields always hold zero
            nxt_ctrl = i_pwdata & rx_dma_ctrl_pkg::RX_DMA_CTRL_WR_MASK;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            ctrl_ff <= rx_dma_ctrl_pkg::RX_DMA_CTRL_RESET;
            pready_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            pready_ff <= nxt_pready;
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Frame acceptance at end of frame
    always_comb begin
        logic rej_runt;
        logic rej_damaged;
        logic rej_crc;
        logic rej_ctrl;
        logic rej_pause;
        logic rej_csum;
        rej_csum = 1'b0;
        rej_runt = (i_frm_len < MIN_LEN) && !ctrl_ff[rx_dma_ctrl_pkg::ACCEPT_RUNT_FRAMES_BIT];
        rej_damaged = (i_frm_dribble || i_frm_code_violation || i_frm_fifo_overflow)
            && !ctrl_ff[rx_dma_ctrl_pkg::ACCEPT_DAMAGED_FRAMES_BIT];
        rej_crc = i_frm_crc_error && !ctrl_ff[rx_dma_ctrl_pkg::ACCEPT_CHECKSUM_FAIL_FRAMES_BIT];
        rej_ctrl = i_frm_is_mac_control && !i_frm_is_pause
            && !ctrl_ff[rx_dma_ctrl_pkg::PASS_MAC_CONTROL_FRAMES_BIT];
        rej_pause = i_frm_is_pause && !ctrl_ff[rx_dma_ctrl_pkg::PASS_FLOW_PAUSE_FRAMES_BIT];
        case (rx_dma_ctrl_pkg::l4_checksum_filter_e'(csum_sel))
            rx_dma_ctrl_pkg::CSUM_REJECT_TCP: begin
                rej_csum = i_frm_is_tcp && i_frm_l4_checksum_bad;
            end
            rx_dma_ctrl_pkg::CSUM_REJECT_TCP_UDP: begin
                rej_csum = (i_frm_is_tcp || i_frm_is_udp) && i_frm_l4_checksum_bad;
            end
            rx_dma_ctrl_pkg::CSUM_RESERVED: begin
                rej_csum = 1'b0;
            end
            default: begin
                rej_csum = 1'b0;
            end
        endcase
        rej_any = rej_runt || rej_damaged || rej_crc || rej_ctrl || rej_pause || rej_csum;
        nxt_decision_valid = i_frm_end;
        nxt_accept = accept_ff;
        nxt_post_status = post_status_ff;
        nxt_stats_only = stats_only_ff;
        nxt_xfer_len = xfer_len_ff;
        nxt_reject_count = reject_count_ff;
        if (i_frm_end) begin
            nxt_accept = !rej_any;
            nxt_post_status = rej_any && ctrl_ff[rx_dma_ctrl_pkg::REPORT_REJECTED_STATUS_BIT]
                && i_long_completion_mode;
            nxt_stats_only = rej_any && !(ctrl_ff[rx_dma_ctrl_pkg::REPORT_REJECTED_STATUS_BIT]
                && i_long_completion_mode);
            if (ctrl_ff[rx_dma_ctrl_pkg::KEEP_FRAME_FCS_BIT] || i_frm_len < FCS_LEN) begin
                nxt_xfer_len = i_frm_len;
            end else begin
                nxt_xfer_len = i_frm_len - FCS_LEN;
            end
            if (rej_any) begin
                nxt_reject_count = reject_count_ff + 8'h01;
            end
        end
        nxt_buf_queue = q_sel;
        nxt_header_split = q_split;
        nxt_start_ok = q_start_ok;
        nxt_cmpl_queue = q_cmpl;
    end

    // Early notify fires once per frame; a new frame start rearms it
    always_comb begin
        nxt_early_fired = early_fired_ff;
        nxt_early_pulse = 1'b0;
        if (i_frm_start) begin
            nxt_early_fired = 1'b0;
        end else if (!early_fired_ff && early_thr != 5'h00 && i_dma_bytes_done >= early_bytes) begin
            nxt_early_fired = 1'b1;
            nxt_early_pulse = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            decision_valid_ff <= 1'b0;
            accept_ff <= 1'b0;
            post_status_ff <= 1'b0;
            stats_only_ff <= 1'b0;
            xfer_len_ff <= '0;
            buf_queue_ff <= 1'b0;
            header_split_ff <= 1'b0;
            start_ok_ff <= 1'b0;
            cmpl_queue_ff <= 1'b0;
            early_fired_ff <= 1'b0;
            early_pulse_ff <= 1'b0;
            reject_count_ff <= 8'h00;
        end else begin
            decision_valid_ff <= nxt_decision_valid;
            accept_ff <= nxt_accept;
            post_status_ff <= nxt_post_status;
            stats_only_ff <= nxt_stats_only;
            xfer_len_ff <= nxt_xfer_len;
            buf_queue_ff <= nxt_buf_queue;
            header_split_ff <= nxt_header_split;
            start_ok_ff <= nxt_start_ok;
            cmpl_queue_ff <= nxt_cmpl_queue;
            early_fired_ff <= nxt_early_fired;
            early_pulse_ff <= nxt_early_pulse;
            reject_count_ff <= nxt_reject_count;
        end
    end

    assign o_pready = pready_ff;
    assign o_prdata = prdata_ff;
    assign o_pslverr = pslverr_ff;
    assign o_decision_valid = decision_valid_ff;
    assign o_frm_accept = accept_ff;
    assign o_frm_post_status = post_status_ff;
    assign o_frm_stats_only = stats_only_ff;
    assign o_xfer_len = xfer_len_ff;
    assign o_buf_queue = buf_queue_ff;
    assign o_header_split = header_split_ff;
    assign o_xfer_start_ok = start_ok_ff;
    assign o_cmpl_queue = cmpl_queue_ff;
    assign o_early_arrival_interrupt = early_pulse_ff;
endmodule : rx_dma_ctrl

// [rx_dma_ctrl_sva.sv]
// Concurrent checks on the receive DMA control block ports
module rx_dma_ctrl_sva #(
    parameter int LEN_W = 16
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic i_long_completion_mode,
    input wire logic i_frm_end,
    input wire logic [LEN_W-1:0] i_frm_len,
    input wire logic i_frm_crc_error,
    input wire logic i_frm_hi_prio,
    input wire logic i_frm_is_ip,
    input wire logic i_fp_queue_override,
    input wire logic i_fp_queue_sel,
    input wire logic i_q1_empty,
    input wire logic i_q2_empty,
    input wire logic [LEN_W-1:0] i_dma_bytes_done,
    input wire logic o_decision_valid,
    input wire logic o_frm_accept,
    input wire logic o_frm_post_status,
    input wire logic [LEN_W-1:0] o_xfer_len,
    input wire logic o_buf_queue,
    input wire logic o_header_split,
    input wire logic o_cmpl_queue,
    input wire logic o_early_arrival_interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] ctrl_ff;
    logic [31:0] nxt_ctrl;
    logic [2:0] mode;
    logic post_en;
    logic [10:0] thr_bytes;
    // Shadow of the control word, updated only by a completed write
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (i_psel && i_penable && i_pwrite && o_pready && i_paddr == rx_dma_ctrl_pkg::RX_DMA_CTRL_OFFSET) begin
            nxt_ctrl = i_pwdata & rx_dma_ctrl_pkg::RX_DMA_CTRL_WR_MASK;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            ctrl_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end
    assign mode = ctrl_ff[22:20];
    assign post_en = ctrl_ff[31] & i_long_completion_mode;
    assign thr_bytes = {ctrl_ff[16:12], 6'h00};
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    sequence s_decide;
        ##1 o_decision_valid;
    endsequence
    property p_runt;
        i_frm_end && i_frm_len < 64 && !ctrl_ff[30] |-> s_decide ##0 !o_frm_accept;
    endproperty
    property p_crc;
        i_frm_end && i_frm_crc_error && !ctrl_ff[28] |-> s_decide ##0 (!o_frm_accept && o_frm_post_status == $past(post_en));
    endproperty
    property p_len;
        i_frm_end && i_frm_len >= 4 |=> o_xfer_len == ($past(ctrl_ff[18]) ? $past(i_frm_len) : LEN_W'($past(i_frm_len) - 4));
    endproperty
    property p_mode0;
        mode == 3'h0 |=> !o_buf_queue && !o_header_split;
    endproperty
    property p_prio;
        mode == 3'h3 && !i_fp_queue_override && !ctrl_ff[19] |=> o_buf_queue == $past(i_frm_hi_prio);
    endproperty
    property p_ovr;
        (mode == 3'h1 || mode == 3'h3) && i_fp_queue_override && !ctrl_ff[19] |=> o_buf_queue == $past(i_fp_queue_sel);
    endproperty
    property p_fallback;
        mode == 3'h1 && !i_fp_queue_override && ctrl_ff[19] && i_q1_empty && !i_q2_empty |=> o_buf_queue;
    endproperty
    property p_split;
        mode == 3'h4 && i_frm_is_ip && !i_fp_queue_override |=> o_header_split && !o_buf_queue;
    endproperty
    property p_cq;
        !ctrl_ff[23] |=> !o_cmpl_queue;
    endproperty
    property p_early;
        o_early_arrival_interrupt |-> ($past(thr_bytes) != 0 && $past(i_dma_bytes_done) >= $past(thr_bytes)) ##1 !o_early_arrival_interrupt;
    endproperty
    a_runt: assert property (p_runt) else $error("short frame accepted");
    a_crc: assert property (p_crc) else $error("crc frame decision wrong");
    a_len: assert property (p_len) else $error("transfer length wrong");
    a_mode0: assert property (p_mode0) else $error("queue 2 used in mode 0");
    a_prio: assert property (p_prio) else $error("priority queue wrong");
    a_ovr: assert property (p_ovr) else $error("override ignored");
    a_fallback: assert property (p_fallback) else $error("fallback not taken");
    a_split: assert property (p_split) else $error("header split wrong");
    a_cq: assert property (p_cq) else $error("second completion queue used");
    a_early: assert property (p_early) else $error("early notify wrong");
endmodule : rx_dma_ctrl_sva

bind rx_dma_ctrl rx_dma_ctrl_sva #(.LEN_W(LEN_W)) u_sva (.*);

// [host_mem_model.sv]
// Host memory side model: bytes of the current frame already written
module host_mem_model #(
    parameter int LEN_W = 16
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_frm_start,
    input wire logic i_stall,
    output logic [LEN_W-1:0] o_dma_bytes_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [LEN_W-1:0] bytes_ff;
    logic [LEN_W-1:0] nxt_bytes;
    // A new frame restarts the count; a stalled bus moves no data
    always_comb begin
        nxt_bytes = bytes_ff;
        if (i_frm_start) begin
            nxt_bytes = '0;
        end else if (!i_stall) begin
            nxt_bytes = bytes_ff + LEN_W'(4);
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            bytes_ff <= '0;
        end else begin
            bytes_ff <= nxt_bytes;
        end
    end
    assign o_dma_bytes_done = bytes_ff;
endmodule : host_mem_model

// [tb_rx_dma_ctrl.sv]
// Self-checking bench for the receive DMA control block
module tb_rx_dma_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk, i_nrst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd, c, r;
    logic i_long_completion_mode, i_frm_end, i_frm_dribble, i_frm_code_violation, i_frm_fifo_overflow;
    logic i_frm_crc_error, i_frm_is_mac_control, i_frm_is_pause, i_frm_is_tcp, i_frm_is_udp, i_frm_l4_checksum_bad;
    logic i_frm_hi_prio, i_frm_is_ip, i_frm_start, i_frm_complete, i_fp_len_valid, i_fp_queue_override;
    logic i_fp_queue_sel, i_fp_cmpl_override, i_fp_cmpl_sel, i_q1_empty, i_q2_empty, stall, er, e;
    logic [15:0] i_frm_len, i_frm_bytes_rcvd, i_second_queue_buffer_bytes, i_fp_len, i_dma_bytes_done, o_xfer_len;
    logic o_decision_valid, o_frm_accept, o_frm_post_status, o_frm_stats_only, o_buf_queue, o_header_split;
    logic o_xfer_start_ok, o_cmpl_queue, o_early_arrival_interrupt;
    logic [2:0] q;
    integer seed = 32'h9FDD;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;

    rx_dma_ctrl DUT (.*);
    host_mem_model u_mem (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_frm_start(i_frm_start),
        .i_stall(stall), .o_dma_bytes_done(i_dma_bytes_done));

    always #12.5 i_core_clk = ~i_core_clk;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task give_verdict();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_psel <= 1'h1;
        i_penable <= 1'h0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_core_clk);
        i_penable <= 1'h1;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (o_pready !== 1'h1 && n < 20);
        if (o_pready !== 1'h1) failures++;
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'h0;
        i_penable <= 1'h0;
    endtask : apb

    function automatic logic rej(input logic [31:0] k);
        logic cs;
        cs = i_frm_l4_checksum_bad & ((k[25:24] == 2'h1 & i_frm_is_tcp) | (k[25:24] == 2'h2 & (i_frm_is_tcp | i_frm_is_udp)));
        return (i_frm_len < 16'h0040 & !k[30]) | ((i_frm_dribble | i_frm_code_violation | i_frm_fifo_overflow) & !k[29])
            | (i_frm_crc_error & !k[28]) | (i_frm_is_mac_control & !i_frm_is_pause & !k[27]) | (i_frm_is_pause & !k[26]) | cs;
    endfunction : rej

    function automatic logic [2:0] qexp(input logic [31:0] k);
        logic qs, sp, ok, kn;
        logic [15:0] l;
        sp = 1'h0;
        ok = 1'h1;
        qs = 1'h0;
        kn = i_fp_len_valid | i_frm_complete;
        l = i_fp_len_valid ? i_fp_len : i_frm_bytes_rcvd;
        case (k[22:20])
            3'h2: begin
                ok = kn || i_frm_bytes_rcvd >= i_second_queue_buffer_bytes;
                qs = kn && l <= i_second_queue_buffer_bytes;
            end
            3'h3: qs = i_frm_hi_prio;
            3'h4: begin
                sp = i_frm_is_ip;
                qs = !i_frm_is_ip;
            end
            default: qs = 1'h0;
        endcase
        if (k[22:20] != 3'h0 && i_fp_queue_override) qs = i_fp_queue_sel;
        if (k[22:20] != 3'h0 && k[19] && !sp && (qs ? i_q2_empty : i_q1_empty)) qs = !qs;
        return {ok, sp, qs};
    endfunction : qexp

    task early_run(input logic [4:0] thr, input int exp_n);
        int n;
        logic [15:0] pb;
        n = 0;
        pb = 16'h0000;
        apb(1'h1, rx_dma_ctrl_pkg::RX_DMA_CTRL_OFFSET, {15'h0000, thr, 12'h000});
        @(posedge i_core_clk);
        i_frm_start <= 1'h1;
        @(posedge i_core_clk);
        i_frm_start <= 1'h0;
        repeat (300) begin
            @(posedge i_core_clk);
            if (o_early_arrival_interrupt === 1'h1) begin
                n++;
                chk(pb, {thr, 6'h00});
            end
            pb = i_dma_bytes_done;
            stall <= 1'($random(seed));
        end
        chk(n, exp_n);
    endtask : early_run

    initial begin
        {i_core_clk, i_nrst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_long_completion_mode, i_frm_end,
            i_frm_len, i_frm_dribble, i_frm_code_violation, i_frm_fifo_overflow, i_frm_crc_error, i_frm_is_mac_control,
            i_frm_is_pause, i_frm_is_tcp, i_frm_is_udp, i_frm_l4_checksum_bad, i_frm_hi_prio, i_frm_is_ip, i_frm_start,
            i_frm_complete, i_frm_bytes_rcvd, i_fp_len_valid, i_fp_len, i_fp_queue_override, i_fp_queue_sel,
            i_fp_cmpl_override, i_fp_cmpl_sel, i_q1_empty, i_q2_empty, stall} = '0;
        i_second_queue_buffer_bytes = 16'h0040;
        repeat (12) @(posedge i_core_clk);
        i_nrst <= 1'h1;
        apb(1'h0, rx_dma_ctrl_pkg::RX_DMA_CTRL_OFFSET, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'h1, rx_dma_ctrl_pkg::RX_DMA_CTRL_OFFSET, 32'hFFFD_FFFF);
        apb(1'h0, rx_dma_ctrl_pkg::RX_DMA_CTRL_OFFSET, 32'h0);
        chk(rd, 32'hFFFD_F000);
        apb(1'h0, 12'h0D4, 32'h0);
        chk(er, 32'h1);
        chk(rd, 32'h0);
        for (int i = 0; i < 200; i++) begin
            c = $random(seed) & 32'hFFFD_F000;
            apb(1'h1, rx_dma_ctrl_pkg::RX_DMA_CTRL_OFFSET, c);
            r = $random(seed);
            @(posedge i_core_clk);
            i_frm_end <= 1'h1;
            i_frm_len <= (i == 0) ? 16'h003F : (i == 1) ? 16'h0040 : 16'h0004 + 16'(r % 126);
            i_long_completion_mode <= r[8];
            {i_frm_dribble, i_frm_code_violation, i_frm_fifo_overflow, i_frm_crc_error} <= r[12:9] & r[16:13];
            {i_frm_is_mac_control, i_frm_is_pause, i_frm_is_tcp, i_frm_is_udp, i_frm_l4_checksum_bad} <= r[21:17];
            @(posedge i_core_clk);
            i_frm_end <= 1'h0;
            #1;
            e = rej(c);
            chk(o_decision_valid, 32'h1);
            chk(!o_frm_accept, e);
            chk(o_frm_post_status, e & c[31] & i_long_completion_mode);
            chk(o_frm_stats_only, e & !(c[31] & i_long_completion_mode));
            chk(o_xfer_len, c[18] ? i_frm_len : i_frm_len - 16'h0004);
        end
        for (int i = 0; i < 300; i++) begin
            c = $random(seed) & 32'hFFFD_F000;
            c[22:20] = 3'(i % 5);
            if (c[22:20] == 3'h4) c[23] = 1'h0;
            apb(1'h1, rx_dma_ctrl_pkg::RX_DMA_CTRL_OFFSET, c);
            r = $random(seed);
            @(posedge i_core_clk);
            i_frm_hi_prio <= r[0];
            i_frm_is_ip <= r[1];
            i_fp_queue_override <= r[2];
            i_fp_queue_sel <= r[3];
            i_fp_cmpl_override <= r[4];
            i_fp_cmpl_sel <= r[5];
            i_q1_empty <= r[6] & (c[22:20] != 3'h2);
            i_q2_empty <= r[7] & !r[6] & (c[22:20] != 3'h2);
            i_fp_len_valid <= r[8];
            i_frm_complete <= r[9] & !r[8];
            i_frm_bytes_rcvd <= (i % 7 == 0) ? 16'h0040 : 16'(r[31:25]);
            i_fp_len <= (i % 7 == 1) ? 16'h0040 : 16'(r[23:17]);
            @(posedge i_core_clk);
            #1;
            q = qexp(c);
            chk(o_buf_queue, q[0]);
            chk(o_header_split, q[1]);
            chk(o_xfer_start_ok, q[2]);
            chk(o_cmpl_queue, c[23] & (i_fp_cmpl_override ? i_fp_cmpl_sel : i_frm_hi_prio));
        end
        early_run(5'h02, 1);
        early_run(5'h00, 0);
        give_verdict();
    end

    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            give_verdict();
        end
    end
endmodule : tb_rx_dma_ctrl
